/* File: design/srq_pkg.sv */
package srq_pkg;
	// Register byte addresses within the block
	localparam logic [7:0]  ADDR_CONTROL_TWO     = 8'h00;
	localparam logic [7:0]  ADDR_DATA      = 8'h04;
	localparam logic [7:0]  ADDR_STAT      = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
	localparam logic [7:0]  ADDR_RATE      = 8'h14;
	localparam logic [7:0]  ADDR_AUX       = 8'h18;
	// Field positions
	localparam int          CNT_LSB        = 8;
	localparam int          WM_LSB         = 6;
	localparam int          QEN_BIT        = 5;
	localparam int          LIN_BIT        = 3;
	localparam int          STAT_LEVEL_BIT = 13;
	localparam int          STAT_SYNC_BIT  = 3;
	localparam int          AUX_DMA_BIT    = 0;
	// Interrupt status and mask layout
	localparam int          IRQ_W          = 5;
	localparam int          IRQ_RX_LEVEL   = 0;
	localparam int          IRQ_SYNC_ERR   = 1;
	localparam int          IRQ_BREAK      = 2;
	localparam int          IRQ_OVERRUN    = 3;
	localparam int          IRQ_AUTOBAUD   = 4;
	// Sizes, counts and reset values
	localparam logic [2:0]  QUEUE_DEPTH    = 3'h4;
	localparam logic [12:0] RATE_RESET     = 13'h0057;
	localparam logic [1:0]  WM_RESET       = 2'h0;
	localparam logic [3:0]  BRK_SAMPLES    = 4'hB;
	localparam logic [7:0]  SYNC_CHAR      = 8'h55;
	localparam logic [2:0]  SYNC_EDGES     = 3'h4;
	localparam logic [12:0] MIN_PERIOD     = 13'h0002;
	// Receiver states
	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP,
		RX_BREAK
	} srq_rx_state_type;
endpackage

/* File: design/srq_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - Receive fill count is three bits, zero to four, never above four.
// - Watermark bits 7-6 pick level flag threshold of one to four words.
// - Queues off: watermark reads 00, flag set when the single buffer holds a word.
// - Bit 5 enables four-deep queues; clear gives single buffering.
// - Bit 4 is reserved and always reads zero.
// - Bits 2-0 are reserved and always read zero.
// - Responder bit 3 clear: divisor keeps exactly what software wrote.
// - Responder mode: eleven consecutive zero samples mean a break.
// - After a break, time the 0x55 sync and reload the divisor.
// - First character after break not 0x55: divisor kept, sync error set.
// - Fill count rises per received word, falls per data read.
// - Level flag clears by status read then data reads; queues or DMA skip status.
module srq_ctrl
	import srq_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        rxd,
	output logic             rx_level_flag,
	output logic             irq
);
	// Threshold of the level flag, shared by logic and checks
	function automatic logic [2:0] level_thr(input logic qen, input logic [1:0] wm);
		level_thr = qen ? 3'({1'b0, wm}) + 3'h1 : 3'h1;
	endfunction

	logic                 wr_pend_reg, rd_wait_reg;
	logic [7:0]           addr_reg;
	logic [31:0]          hrdata_reg, rd_word;
	logic [1:0]           wm_reg;
	logic                 qen_reg, lin_reg, dma_reg, arm_reg, level_reg;
	logic [IRQ_W-1:0]     irq_stat_reg, irq_mask_reg, irq_ev;
	logic [12:0]          rate_reg, per, tmr_reg, new_rate;
	logic [7:0]           q_mem [4];
	logic [1:0]           wr_ptr_reg, rd_ptr_reg;
	logic [2:0]           count_reg, count_next, cap, bitn_reg, edges_reg;
	srq_rx_state_type     rx_state_reg;
	logic [7:0]           shift_reg;
	logic [3:0]           zrun_reg;
	logic                 rxd_prev_reg, sync_pend_reg, meas_on_reg, meas_done_reg;
	logic [15:0]          meas_reg;
	logic                 accept, wr_en, pop, push, push_ok, overrun, stat_read;
	logic                 tick, done_ok, frame_zero, brk_hit, fall, sync_ok;
	logic                 autobaud_load, sync_err_ev, level_rise, data_rd;

	// Bus address phase; reads take one wait state so data is fresh
	assign accept    = hsel & hready & htrans[1];
	assign hreadyout = ~rd_wait_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign wr_en     = wr_pend_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			addr_reg    <= 8'h00;
		end else begin
			wr_pend_reg <= accept & hwrite;
			rd_wait_reg <= accept & ~hwrite;
			if (accept)
				addr_reg <= haddr[7:0];
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (addr_reg)
			ADDR_CONTROL_TWO: begin
				rd_word[CNT_LSB +: 3] = count_reg;
				rd_word[WM_LSB +: 2]  = qen_reg ? wm_reg : 2'h0;
				rd_word[QEN_BIT]      = qen_reg;
				rd_word[LIN_BIT]      = lin_reg;
			end
			ADDR_DATA:     rd_word[7:0] = (count_reg != 3'h0) ? q_mem[rd_ptr_reg] : 8'h00;
			ADDR_STAT: begin
				rd_word[STAT_LEVEL_BIT] = level_reg;
				rd_word[STAT_SYNC_BIT]  = irq_stat_reg[IRQ_SYNC_ERR];
			end
			ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat_reg;
			ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_reg;
			ADDR_RATE:     rd_word[12:0] = rate_reg;
			ADDR_AUX:      rd_word[AUX_DMA_BIT] = dma_reg;
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	// Read data register, loaded in the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_reg <= 32'h0000_0000;
		else if (rd_wait_reg)
			hrdata_reg <= rd_word;
	end

	// Software control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wm_reg       <= WM_RESET;
			qen_reg      <= 1'b0;
			lin_reg      <= 1'b0;
			dma_reg      <= 1'b0;
			irq_mask_reg <= '0;
		end else if (wr_en) begin
			if (addr_reg == ADDR_CONTROL_TWO) begin
				wm_reg  <= hwdata[WM_LSB +: 2];
				qen_reg <= hwdata[QEN_BIT];
				lin_reg <= hwdata[LIN_BIT];
			end
			if (addr_reg == ADDR_AUX)
				dma_reg <= hwdata[AUX_DMA_BIT];
			if (addr_reg == ADDR_IRQ_MASK)
				irq_mask_reg <= hwdata[IRQ_W-1:0];
		end
	end

	// Divisor: software write wins over an automatic reload
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rate_reg <= RATE_RESET;
		else if (wr_en && addr_reg == ADDR_RATE)
			rate_reg <= hwdata[12:0];
		else if (autobaud_load)
			rate_reg <= new_rate;
	end

	// Bit timing from the live divisor, floored so the timer can turn over
	assign per  = (rate_reg < MIN_PERIOD) ? MIN_PERIOD : rate_reg;
	assign tick = (tmr_reg == per - 13'h0001);

	// Receiver: start, eight data bits, stop, and zero-run tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg <= RX_IDLE;
			tmr_reg      <= 13'h0000;
			bitn_reg     <= 3'h0;
			shift_reg    <= 8'h00;
			zrun_reg     <= 4'h0;
		end else begin
			case (rx_state_reg)
				RX_IDLE: begin
					tmr_reg <= 13'h0000;
					if (!rxd)
						rx_state_reg <= RX_START;
				end
				RX_START: begin
					if (tmr_reg == (per >> 1)) begin
						tmr_reg  <= 13'h0000;
						bitn_reg <= 3'h0;
						zrun_reg <= 4'h1;
						rx_state_reg <= rxd ? RX_IDLE : RX_DATA;   // Glitch rejected
					end else
						tmr_reg <= tmr_reg + 13'h0001;
				end
				RX_DATA: begin
					if (tick) begin
						tmr_reg   <= 13'h0000;
						shift_reg <= {rxd, shift_reg[7:1]};
						zrun_reg  <= rxd ? 4'h0 : zrun_reg + 4'h1;
						bitn_reg  <= bitn_reg + 3'h1;
						if (bitn_reg == 3'h7)
							rx_state_reg <= RX_STOP;
					end else
						tmr_reg <= tmr_reg + 13'h0001;
				end
				RX_STOP: begin
					if (tick) begin
						tmr_reg <= 13'h0000;
						if (!rxd) begin
							zrun_reg     <= zrun_reg + 4'h1;
							rx_state_reg <= RX_BREAK;
						end else
							rx_state_reg <= RX_IDLE;
					end else
						tmr_reg <= tmr_reg + 13'h0001;
				end
				RX_BREAK: begin
					// Stay until the line returns high, counting zero samples
					if (rxd)
						rx_state_reg <= RX_IDLE;
					else if (tick) begin
						tmr_reg <= 13'h0000;
						if (zrun_reg != 4'hF)
							zrun_reg <= zrun_reg + 4'h1;
					end else
						tmr_reg <= tmr_reg + 13'h0001;
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// Character events
	assign done_ok    = (rx_state_reg == RX_STOP) & tick & rxd;
	assign frame_zero = (rx_state_reg == RX_STOP) & tick & ~rxd;
	assign brk_hit    = lin_reg & (rx_state_reg == RX_BREAK) & ~rxd & tick
	                    & (zrun_reg == BRK_SAMPLES - 4'h1);
	assign fall       = rxd_prev_reg & ~rxd;

	// Sync timing: start edge to fifth falling edge spans eight bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_prev_reg  <= 1'b1;
			sync_pend_reg <= 1'b0;
			meas_on_reg   <= 1'b0;
			meas_done_reg <= 1'b0;
			meas_reg      <= 16'h0000;
			edges_reg     <= 3'h0;
		end else begin
			rxd_prev_reg <= rxd;
			if (brk_hit) begin
				sync_pend_reg <= 1'b1;
				meas_on_reg   <= 1'b0;
				meas_done_reg <= 1'b0;
			end else if (!lin_reg || (sync_pend_reg && (done_ok || frame_zero))) begin
				sync_pend_reg <= 1'b0;
				meas_on_reg   <= 1'b0;
				meas_done_reg <= 1'b0;
			end else if (sync_pend_reg && rx_state_reg == RX_IDLE && fall
			             && !meas_on_reg && !meas_done_reg) begin
				meas_on_reg <= 1'b1;
				meas_reg    <= 16'h0000;
				edges_reg   <= 3'h0;
			end else if (meas_on_reg) begin
				if (meas_reg != 16'hFFFF)
					meas_reg <= meas_reg + 16'h0001;
				if (fall) begin
					edges_reg <= edges_reg + 3'h1;
					if (edges_reg == SYNC_EDGES - 3'h1) begin
						meas_on_reg   <= 1'b0;
						meas_done_reg <= 1'b1;
					end
				end
			end
		end
	end

	// Rounded cycles per bit; sync character itself is not queued
	assign new_rate      = 13'((meas_reg + 16'h0004) >> 3);
	assign sync_ok       = (shift_reg == SYNC_CHAR) & meas_done_reg;
	assign autobaud_load = done_ok & sync_pend_reg & sync_ok;
	assign sync_err_ev   = sync_pend_reg & ((done_ok & ~sync_ok) | frame_zero);

	// Receive queue, one word deep while queues are off
	assign cap        = qen_reg ? QUEUE_DEPTH : 3'h1;
	assign stat_read  = rd_wait_reg & (addr_reg == ADDR_STAT);
	assign data_rd    = rd_wait_reg & (addr_reg == ADDR_DATA);    // Empty reads count too
	assign pop        = data_rd & (count_reg != 3'h0);
	assign push       = done_ok & ~sync_pend_reg;
	assign push_ok    = push & ((count_reg < cap) | pop);
	assign overrun    = push & ~push_ok;
	assign count_next = count_reg + {2'h0, push_ok} - {2'h0, pop};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg  <= 3'h0;
			wr_ptr_reg <= 2'h0;
			rd_ptr_reg <= 2'h0;
		end else begin
			count_reg <= count_next;
			if (push_ok)
				wr_ptr_reg <= wr_ptr_reg + 2'h1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 2'h1;
		end
	end

	// Storage holds no control state, so it needs no reset
	always_ff @(posedge hclk) begin
		if (push_ok)
			q_mem[wr_ptr_reg] <= shift_reg;
	end

	// Level flag: sticky until the documented clearing sequence
	assign level_rise    = ~level_reg & (count_next >= level_thr(qen_reg, wm_reg));
	assign rx_level_flag = level_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_reg <= 1'b0;
			arm_reg   <= 1'b0;
		end else begin
			if (count_next >= level_thr(qen_reg, wm_reg))
				level_reg <= 1'b1;
			else if (data_rd && (qen_reg || dma_reg || arm_reg))
				level_reg <= 1'b0;
			if (stat_read && level_reg)
				arm_reg <= 1'b1;
			else if (data_rd)
				arm_reg <= 1'b0;
		end
	end

	// Sticky interrupt status; a new event beats a same-cycle clear
	always_comb begin
		irq_ev = '0;
		irq_ev[IRQ_RX_LEVEL] = level_rise;
		irq_ev[IRQ_SYNC_ERR] = sync_err_ev;
		irq_ev[IRQ_BREAK]    = brk_hit;
		irq_ev[IRQ_OVERRUN]  = overrun;
		irq_ev[IRQ_AUTOBAUD] = autobaud_load;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_stat_reg <= '0;
		else if (wr_en && addr_reg == ADDR_IRQ_STAT)
			irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_ev;
		else
			irq_stat_reg <= irq_stat_reg | irq_ev;
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_count_in_range: assert property (count_reg <= QUEUE_DEPTH)
		else $error("fill count above four");
	a_level_at_thr: assert property (
		count_reg >= level_thr(qen_reg, wm_reg) |-> level_reg)
		else $error("level flag low at threshold");
	a_wm_forced_zero: assert property (
		rd_wait_reg && addr_reg == ADDR_CONTROL_TWO && !qen_reg |=> hrdata[7:6] == 2'h0)
		else $error("watermark not forced while queues off");
	a_single_buffer: assert property (!qen_reg |-> ##1 count_reg <= 3'h1 || $past(qen_reg))
		else $error("single buffer holds more than one word");
	a_bit4_zero: assert property (
		rd_wait_reg && addr_reg == ADDR_CONTROL_TWO |=> hrdata[4] == 1'b0)
		else $error("reserved bit 4 not zero");
	a_low_bits_zero: assert property (
		rd_wait_reg && addr_reg == ADDR_CONTROL_TWO |=> hrdata[2:0] == 3'h0)
		else $error("reserved bits 2-0 not zero");
	a_rate_kept: assert property (
		!lin_reg && !(wr_en && addr_reg == ADDR_RATE) |=> $stable(rate_reg))
		else $error("divisor changed without a write");
	a_break_pending: assert property (brk_hit |=> sync_pend_reg && irq_stat_reg[IRQ_BREAK])
		else $error("break not recorded");
	a_sync_reload: assert property (
		autobaud_load && !(wr_en && addr_reg == ADDR_RATE) |=> rate_reg == $past(new_rate))
		else $error("divisor not reloaded after sync");
	a_sync_mismatch: assert property (
		done_ok && sync_pend_reg && !sync_ok && !wr_en
		|=> $stable(rate_reg) && irq_stat_reg[IRQ_SYNC_ERR])
		else $error("bad sync altered divisor or missed flag");
	a_fill_rises: assert property (push_ok && !pop |=> count_reg == $past(count_reg) + 3'h1)
		else $error("fill count did not rise");
	a_level_clears: assert property (
		pop && qen_reg && count_next < level_thr(qen_reg, wm_reg) |=> !level_reg)
		else $error("level flag not cleared by data read");

	c_autobaud: cover property (autobaud_load);
	c_sync_error: cover property (sync_err_ev);
	c_queue_full: cover property (qen_reg && count_reg == QUEUE_DEPTH);
	c_overrun: cover property (overrun);
endmodule

/* File: tb/srq_lin_master.sv */
`timescale 1ns/1ps
module srq_lin_master (
	input  wire logic hclk,
	output logic      rxd
);
	// Line rests high on its pull-up outside frames
	initial begin
		rxd = 1'b1;
	end

	// One 8N1 character, LSB first, bit time in hclk cycles
	task automatic send_byte(input logic [7:0] b, input int bit_cyc);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bit_cyc) @(posedge hclk);
		end
	endtask

	// Thirteen low bit times, well past the eleven sample threshold, then delimiter
	task automatic send_break(input int bit_cyc);
		rxd <= 1'b0;
		repeat (13 * bit_cyc) @(posedge hclk);
		rxd <= 1'b1;
		repeat (2 * bit_cyc) @(posedge hclk);
	endtask
endmodule

/* File: tb/test_serial_rx_queue_lin_autobaud.sv */
`timescale 1ns/1ps
module test_serial_rx_queue_lin_autobaud;
	import srq_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        rxd;
	logic        rx_level_flag;
	logic        irq;
	int          n_errors;
	int          tests_run;

	assign hready = hreadyout;

	srq_ctrl dut (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.hsel          (hsel),
		.haddr         (haddr),
		.htrans        (htrans),
		.hwrite        (hwrite),
		.hsize         (hsize),
		.hwdata        (hwdata),
		.hready        (hready),
		.hreadyout     (hreadyout),
		.hresp         (hresp),
		.hrdata        (hrdata),
		.rxd           (rxd),
		.rx_level_flag (rx_level_flag),
		.irq           (irq)
	);

	srq_lin_master lin (
		.hclk (hclk),
		.rxd  (rxd)
	);

	// 10 MHz bus clock
	always begin
		#50 hclk = ~hclk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			n_errors++;
		end
	endtask

	// Single word transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(n, e, q);
	endtask

	// Pin checks at the falling edge, once register updates have landed
	task automatic pinchk(input string n, input logic e, input logic g_sel);
		@(negedge hclk);
		chk(n, {31'h0, e}, {31'h0, g_sel ? irq : rx_level_flag});
		@(posedge hclk);
	endtask

	task automatic rx(input logic [7:0] b, input int cyc);
		lin.send_byte(b, cyc);
		repeat (4) @(posedge hclk);
	endtask

	task automatic t_reset_fields;
		rdchk("control_two_reset", ADDR_CONTROL_TWO, 32'h00000000);
		rdchk("rate_reset", ADDR_RATE, 32'h00000057);
		wr(ADDR_CONTROL_TWO, 32'h0000FFFF);
		rdchk("control_two_ones", ADDR_CONTROL_TWO, 32'h000000E8);
		wr(ADDR_CONTROL_TWO, 32'h000000C0);
		rdchk("control_two_wm_forced", ADDR_CONTROL_TWO, 32'h00000000);
	endtask

	// Single buffer: second byte refused, flag needs a status read to clear
	task automatic t_single_buffer;
		rx(8'hA5, 87);
		rdchk("count_one", ADDR_CONTROL_TWO, 32'h00000100);
		pinchk("flag_single", 1'b1, 1'b0);
		rx(8'h3C, 87);
		rdchk("count_held", ADDR_CONTROL_TWO, 32'h00000100);
		rdchk("data_a5", ADDR_DATA, 32'h000000A5);
		pinchk("flag_sticky", 1'b1, 1'b0);
		rdchk("stat_flag", ADDR_STAT, 32'h00002000);
		rdchk("data_empty", ADDR_DATA, 32'h00000000);
		pinchk("flag_cleared", 1'b0, 1'b0);
	endtask

	task automatic t_queue_irq;
		wr(ADDR_CONTROL_TWO, 32'h00000060);
		for (int i = 0; i < 5; i++) begin
			rx(8'h11 * (i + 1), 87);
			rdchk("count_up", ADDR_CONTROL_TWO, (((i < 4) ? i + 1 : 4) << 8) | 32'h60);
			pinchk("flag_wm", i >= 1, 1'b0);
		end
		rdchk("irq_stat", ADDR_IRQ_STAT, 32'h00000009);
		pinchk("irq_masked", 1'b0, 1'b1);
		wr(ADDR_IRQ_MASK, 32'h00000001);
		pinchk("irq_on", 1'b1, 1'b1);
		for (int j = 0; j < 4; j++) begin
			rdchk("data_pop", ADDR_DATA, 8'h11 * (j + 1));
			pinchk("flag_pop", j < 2, 1'b0);
		end
		wr(ADDR_IRQ_STAT, 32'h0000001F);
		pinchk("irq_clear", 1'b0, 1'b1);
		wr(ADDR_IRQ_MASK, 32'h00000000);
		wr(ADDR_CONTROL_TWO, 32'h00000000);
	endtask

	task automatic t_lin;
		lin.send_break(87);
		rx(8'h55, 87);
		rdchk("rate_kept", ADDR_RATE, 32'h00000057);
		rdchk("stat_off", ADDR_STAT, 32'h00002000);
		rdchk("data_55", ADDR_DATA, 32'h00000055);
		wr(ADDR_IRQ_STAT, 32'h0000001F);
		wr(ADDR_CONTROL_TWO, 32'h00000008);
		// Master at 84 cycles a bit; close enough that 87 still frames the sync
		lin.send_break(84);
		rx(8'h55, 84);
		rdchk("rate_auto", ADDR_RATE, 32'h00000054);
		rdchk("sync_unqueued", ADDR_CONTROL_TWO, 32'h00000008);
		rdchk("irq_auto", ADDR_IRQ_STAT, 32'h00000014);
		rx(8'h42, 84);
		rdchk("data_new_rate", ADDR_DATA, 32'h00000042);
		lin.send_break(84);
		rx(8'h33, 84);
		rdchk("rate_bad_sync", ADDR_RATE, 32'h00000054);
		rdchk("stat_sync_err", ADDR_STAT, 32'h00002008);
	endtask

	task automatic report_and_stop;
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog well beyond the roughly 14k cycles the sequence needs
	initial begin
		repeat (80000) @(posedge hclk);
		n_errors++;
		report_and_stop();
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset_fields();
		t_single_buffer();
		t_queue_irq();
		t_lin();
		report_and_stop();
	end
endmodule
